// ===== inc/pscr_pkg.sv
// package of register offsets, field positions and timing counts for the power control bank
package pscr_pkg;
	// ----------------------------------------------------------------
	// register indices; the bus address is a word index, not a byte address
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_DOUBLER_CLOCK_CTRL  = 8'h15;
	localparam logic [7:0] REG_SUPPLY_CTRL         = 8'h1c;
	localparam logic [7:0] REG_ANALOG_ENABLES      = 8'h1d;
	localparam logic [7:0] REG_BATTERY_STATUS      = 8'h1f;
	localparam logic [7:0] REG_CLOCK_GATING        = 8'h14;
	localparam logic [7:0] REG_IRQ_STATUS          = 8'h20;
	localparam logic [7:0] REG_IRQ_MASK            = 8'h21;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_DOUBLER_ENABLE     = 6;
	localparam int BIT_DIVIDER_SELECT     = 0;
	localparam int BIT_CLOCK_SOURCE       = 0;
	localparam int BIT_SUPPLY_SWITCH      = 4;
	localparam int BIT_INPUT_SEL_LO       = 2;
	localparam int BIT_COMPARATOR_ENABLE  = 1;
	localparam int BIT_REF_TEMP_ENABLE    = 6;
	localparam int BIT_REGULATOR_ENABLE   = 5;
	localparam int BIT_GROUND_ENABLE      = 1;
	localparam int BIT_BIAS_ENABLE        = 0;
	localparam int BIT_RESULT             = 0;
	// writable-bit masks of each register except the read-only battery status
	localparam logic [7:0] MASK_DOUBLER_CLOCK_CTRL = 8'h41;
	localparam logic [7:0] MASK_SUPPLY_CTRL        = 8'h1e;
	localparam logic [7:0] MASK_ANALOG_ENABLES     = 8'h63;
	localparam logic [7:0] MASK_CLOCK_GATING       = 8'h01;
	localparam logic [7:0] MASK_IRQ                = 8'h03;
	// interrupt status bit positions
	localparam int IRQ_RESULT_RISE = 0;
	localparam int IRQ_RESULT_FALL = 1;
	// ----------------------------------------------------------------
	// reset values and divider ratios
	// ----------------------------------------------------------------
	localparam logic [7:0] RESET_VALUE   = 8'h00;
	localparam int         DIV_SLOW      = 200;
	localparam int         DIV_FAST      = 100;
	localparam int         DIV_EXTERNAL  = 32;
	localparam int         DIV_WIDTH     = 8;
	// comparator input selector codes
	localparam logic [1:0] SEL_TAP_HALF  = 2'h0;
	localparam logic [1:0] SEL_TAP_THIRD = 2'h1;
	localparam logic [1:0] SEL_EXT_AIN   = 2'h2;
	localparam logic [1:0] SEL_FLOATING  = 2'h3;
endpackage : pscr_pkg

// ===== verilog/pscr_regs.sv
// power system control register bank with avalon slave, doubler clock divider and interrupt
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - doubler clock control bit 6 turns the charge pump on or off.
// - doubler clock is main clock /100 when select is one, /200 when zero.
// - with clock source bit set, select is ignored and external clock /32 is used.
// - supply control bit 4 connects regulated supply to the supply output pin.
// - bits 3-2 pick half tap, third tap, external input four, or floating.
// - supply control bit 1 enables the low battery comparator.
// - analog enables bit 6 enables bandgap reference and temperature sensor together.
// - analog enables bit 5 turns the analog regulator on.
// - analog enables bit 1 enables the analog ground generator at half supply.
// - analog enables bit 0 enables the analog bias circuit.
// - status bit 0 reads the comparator result, one above the threshold.
module pscr_regs (
	// clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       resetn,
	// avalon-mm slave
	input  wire logic [7:0]                 avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	input  wire logic [3:0]                 avs_byteenable,
	output logic      [31:0]                avs_readdata,
	output logic                            avs_waitrequest,
	output logic      [1:0]                 avs_response,
	// clock and comparator inputs from outside
	input  wire logic                       external_clock,
	input  wire logic                       battery_compare_result,
	// analog block controls
	output logic                            doubler_enable,
	output logic                            doubler_clock_enable,
	output logic                            supply_output_switch_enable,
	output logic      [1:0]                 battery_compare_input_select,
	output logic                            battery_comparator_enable,
	output logic                            reference_and_temp_sensor_enable,
	output logic                            regulator_enable,
	output logic                            analog_ground_enable,
	output logic                            analog_bias_enable,
	// interrupt
	output logic                            irq
);
	import pscr_pkg::*;

	localparam logic [pscr_pkg::DIV_WIDTH-1:0] TERM_SLOW = DIV_WIDTH'(DIV_SLOW - 1);
	localparam logic [pscr_pkg::DIV_WIDTH-1:0] TERM_FAST = DIV_WIDTH'(DIV_FAST - 1);
	localparam logic [pscr_pkg::DIV_WIDTH-1:0] TERM_EXT  = DIV_WIDTH'(DIV_EXTERNAL - 1);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [2:0] ext_sync;
	logic [2:0] next_ext_sync;
	logic [2:0] res_sync;
	logic [2:0] next_res_sync;
	logic       ext_level;
	logic       next_ext_level;
	logic       res_level;
	logic       next_res_level;

	// a change is taken only when stages two and three agree
	always_comb begin
		next_ext_sync  = {ext_sync[1:0], external_clock};
		next_res_sync  = {res_sync[1:0], battery_compare_result};
		next_ext_level = (ext_sync[2] == ext_sync[1]) ? ext_sync[2] : ext_level;
		next_res_level = (res_sync[2] == res_sync[1]) ? res_sync[2] : res_level;
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ext_sync  <= 3'h0;
			res_sync  <= 3'h0;
			ext_level <= 1'b0;
			res_level <= 1'b0;
		end else begin
			ext_sync  <= next_ext_sync;
			res_sync  <= next_res_sync;
			ext_level <= next_ext_level;
			res_level <= next_res_level;
		end
	end

	// ----------------------------------------------------------------
	// register storage and bus slave
	// ----------------------------------------------------------------
	logic [7:0]  doubler_clock_ctrl;
	logic [7:0]  supply_output_and_battery_ctrl;
	logic [7:0]  analog_block_enables;
	logic [7:0]  clock_gating;
	logic [7:0]  irq_status;
	logic [7:0]  irq_mask;
	logic        resp_pending;
	logic [7:0]  next_doubler_clock_ctrl;
	logic [7:0]  next_supply_output_and_battery_ctrl;
	logic [7:0]  next_analog_block_enables;
	logic [7:0]  next_clock_gating;
	logic [7:0]  next_irq_status;
	logic [7:0]  next_irq_mask;
	logic        next_resp_pending;
	logic [31:0] next_readdata;
	logic [1:0]  next_response;
	logic [7:0]  irq_events;
	logic        res_prev;
	logic        next_res_prev;
	logic        wr_low;
	logic        access;

	// one wait cycle per access so read data and response come from flops
	always_comb begin
		access        = (avs_read | avs_write) & ~resp_pending;
		wr_low        = avs_write & access & avs_byteenable[0];
		next_doubler_clock_ctrl             = doubler_clock_ctrl;
		next_supply_output_and_battery_ctrl = supply_output_and_battery_ctrl;
		next_analog_block_enables           = analog_block_enables;
		next_clock_gating                   = clock_gating;
		next_irq_mask                       = irq_mask;
		next_readdata     = 32'h0;
		next_response     = 2'h0;
		next_resp_pending = access;
		next_res_prev     = res_level;
		// result edges are the block's events
		irq_events = 8'h0;
		irq_events[IRQ_RESULT_RISE] = res_level & ~res_prev;
		irq_events[IRQ_RESULT_FALL] = ~res_level & res_prev;
		next_irq_status = irq_status;
		if (access) begin
			if (avs_address == REG_DOUBLER_CLOCK_CTRL) begin
				next_readdata = {24'h0, doubler_clock_ctrl};
				if (wr_low)
					next_doubler_clock_ctrl = avs_writedata[7:0] & MASK_DOUBLER_CLOCK_CTRL;
			end else if (avs_address == REG_SUPPLY_CTRL) begin
				next_readdata = {24'h0, supply_output_and_battery_ctrl};
				if (wr_low)
					next_supply_output_and_battery_ctrl = avs_writedata[7:0] & MASK_SUPPLY_CTRL;
			end else if (avs_address == REG_ANALOG_ENABLES) begin
				next_readdata = {24'h0, analog_block_enables};
				if (wr_low)
					next_analog_block_enables = avs_writedata[7:0] & MASK_ANALOG_ENABLES;
			end else if (avs_address == REG_BATTERY_STATUS) begin
				next_readdata = {31'h0, res_level};
			end else if (avs_address == REG_CLOCK_GATING) begin
				next_readdata = {24'h0, clock_gating};
				if (wr_low)
					next_clock_gating = avs_writedata[7:0] & MASK_CLOCK_GATING;
			end else if (avs_address == REG_IRQ_STATUS) begin
				next_readdata = {24'h0, irq_status};
				if (wr_low)
					next_irq_status = irq_status & ~(avs_writedata[7:0] & MASK_IRQ);
			end else if (avs_address == REG_IRQ_MASK) begin
				next_readdata = {24'h0, irq_mask};
				if (wr_low)
					next_irq_mask = avs_writedata[7:0] & MASK_IRQ;
			end else begin
				next_response = 2'h2; // unmapped address answers slave error
			end
		end
		// a new event wins over a clear in the same cycle
		next_irq_status = next_irq_status | irq_events;
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			doubler_clock_ctrl             <= RESET_VALUE;
			supply_output_and_battery_ctrl <= RESET_VALUE;
			analog_block_enables           <= RESET_VALUE;
			clock_gating                   <= RESET_VALUE;
			irq_status                     <= RESET_VALUE;
			irq_mask                       <= RESET_VALUE;
			resp_pending                   <= 1'b0;
			res_prev                       <= 1'b0;
			avs_readdata                   <= 32'h0;
			avs_response                   <= 2'h0;
			avs_waitrequest                <= 1'b1;
			irq                            <= 1'b0;
		end else begin
			doubler_clock_ctrl             <= next_doubler_clock_ctrl;
			supply_output_and_battery_ctrl <= next_supply_output_and_battery_ctrl;
			analog_block_enables           <= next_analog_block_enables;
			clock_gating                   <= next_clock_gating;
			irq_status                     <= next_irq_status;
			irq_mask                       <= next_irq_mask;
			resp_pending                   <= next_resp_pending;
			res_prev                       <= next_res_prev;
			avs_readdata                   <= next_readdata;
			avs_response                   <= next_response;
			avs_waitrequest                <= ~next_resp_pending;
			irq                            <= |(next_irq_status & next_irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// doubler clock divider
	// ----------------------------------------------------------------
	logic [DIV_WIDTH-1:0] div_count;
	logic [DIV_WIDTH-1:0] next_div_count;
	logic [DIV_WIDTH-1:0] div_term;
	logic                 ext_prev;
	logic                 next_ext_prev;
	logic                 tick;
	logic                 next_clock_enable;

	// the external source counts rising edges of the synchronised pin
	always_comb begin
		next_ext_prev = ext_level;
		if (clock_gating[BIT_CLOCK_SOURCE]) begin
			div_term = TERM_EXT;
			tick     = ext_level & ~ext_prev;
		end else begin
			div_term = doubler_clock_ctrl[BIT_DIVIDER_SELECT] ? TERM_FAST : TERM_SLOW;
			tick     = 1'b1;
		end
		next_div_count    = div_count;
		next_clock_enable = 1'b0;
		if (!doubler_clock_ctrl[BIT_DOUBLER_ENABLE]) begin
			next_div_count = '0;
		end else if (tick) begin
			if (div_count >= div_term) begin
				next_div_count    = '0;
				next_clock_enable = 1'b1;
			end else begin
				next_div_count = div_count + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			div_count            <= '0;
			ext_prev             <= 1'b0;
			doubler_clock_enable <= 1'b0;
		end else begin
			div_count            <= next_div_count;
			ext_prev             <= next_ext_prev;
			doubler_clock_enable <= next_clock_enable;
		end
	end

	// ----------------------------------------------------------------
	// static analog control levels
	// ----------------------------------------------------------------
	// registered copies keep every output straight from a flop
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			doubler_enable                   <= 1'b0;
			supply_output_switch_enable      <= 1'b0;
			battery_compare_input_select     <= SEL_TAP_HALF;
			battery_comparator_enable        <= 1'b0;
			reference_and_temp_sensor_enable <= 1'b0;
			regulator_enable                 <= 1'b0;
			analog_ground_enable             <= 1'b0;
			analog_bias_enable               <= 1'b0;
		end else begin
			doubler_enable <= next_doubler_clock_ctrl[BIT_DOUBLER_ENABLE];
			supply_output_switch_enable <=
				next_supply_output_and_battery_ctrl[BIT_SUPPLY_SWITCH];
			battery_compare_input_select <=
				next_supply_output_and_battery_ctrl[BIT_INPUT_SEL_LO +: 2];
			battery_comparator_enable <=
				next_supply_output_and_battery_ctrl[BIT_COMPARATOR_ENABLE];
			reference_and_temp_sensor_enable <=
				next_analog_block_enables[BIT_REF_TEMP_ENABLE];
			regulator_enable     <= next_analog_block_enables[BIT_REGULATOR_ENABLE];
			analog_ground_enable <= next_analog_block_enables[BIT_GROUND_ENABLE];
			analog_bias_enable   <= next_analog_block_enables[BIT_BIAS_ENABLE];
		end
	end

endmodule : pscr_regs
`default_nettype wire

// ===== verif/pscr_regs_props.sv
// checker of bus timing and register-to-output relations of the power control bank
`timescale 1ns/1ns
`default_nettype none
module pscr_regs_props
	import pscr_pkg::*;
(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        resetn,
	// avalon-mm slave
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [1:0]  avs_response,
	// analog block controls
	input wire logic        doubler_enable,
	input wire logic        doubler_clock_enable,
	input wire logic        supply_output_switch_enable,
	input wire logic [1:0]  battery_compare_input_select,
	input wire logic        battery_comparator_enable,
	input wire logic        reference_and_temp_sensor_enable,
	input wire logic        regulator_enable,
	input wire logic        analog_ground_enable,
	input wire logic        analog_bias_enable
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	logic       wr_done;
	logic [8:0] ctl;
	// a write counts only on its answer cycle and with the low byte enabled
	assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
	assign ctl = {doubler_enable, supply_output_switch_enable, battery_compare_input_select,
		battery_comparator_enable, reference_and_temp_sensor_enable, regulator_enable,
		analog_ground_enable, analog_bias_enable};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
		else $error("bus access not answered in time");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	unmapped_resp_a: assert property (!avs_waitrequest && !(avs_address inside {8'h14, 8'h15, 8'h1c,
		8'h1d, 8'h1f, 8'h20, 8'h21}) |-> avs_response == 2'h2) else $error("unmapped access not refused");
	read_width_a: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h0)
		else $error("read data above bit 7 not zero");
	doubler_write_a: assert property (wr_done &&
		avs_address == REG_DOUBLER_CLOCK_CTRL |-> doubler_enable == avs_writedata[6])
		else $error("doubler enable not from bit 6");
	supply_write_a: assert property (wr_done &&
		avs_address == REG_SUPPLY_CTRL |-> ctl[7:4] == avs_writedata[4:1])
		else $error("supply controls not from bits 4-1");
	analog_write_a: assert property (wr_done &&
		avs_address == REG_ANALOG_ENABLES
		|-> ctl[3:0] == {avs_writedata[6:5], avs_writedata[1:0]}) else $error("analog enables wrong");
	static_level_a: assert property ($changed(ctl) |-> avs_write && !avs_waitrequest)
		else $error("control output changed without a write");
	pump_gate_a: assert property ((!doubler_enable) [*2] |-> !doubler_clock_enable)
		else $error("doubler clock pulses while pump is off");
endmodule : pscr_regs_props
bind pscr_regs pscr_regs_props u_props (.ref_clk, .resetn, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
	.doubler_enable, .doubler_clock_enable, .supply_output_switch_enable,
	.battery_compare_input_select, .battery_comparator_enable, .reference_and_temp_sensor_enable,
	.regulator_enable, .analog_ground_enable, .analog_bias_enable);
`default_nettype wire

// ===== verif/test_pscr_regs.sv
// self-checking bench of the power control register bank
`timescale 1ns/1ns
`default_nettype none
module test_pscr_regs;
	import pscr_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic        external_clock = 1'b0;
	logic        battery_compare_result = 1'b0;
	logic [2:0]  ext_div = 3'h0;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest;
	wire  [1:0]  avs_response;
	wire  [8:0]  ctl;
	wire         doubler_clock_enable;
	wire         irq;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic [7:0]  exp_clk_ctrl = 8'h00;
	logic [7:0]  exp_supply = 8'h00;
	logic [7:0]  exp_analog = 8'h00;
	int          n_errors = 0;
	int          n_tests = 0;
	int          k;
	// rows of {index, write data, read back}; the chain comes up before ground and comparator
	logic [23:0] rows [18] = '{24'h15ff41, 24'h150000, 24'h154141, 24'h1d2020,
		24'h1d2121, 24'h1d6363, 24'h1d2323, 24'h1d6161, 24'h1d4141, 24'h1d4040, 24'h1d2121,
		24'h1dff63, 24'h1c1e1e, 24'h1c0404, 24'h1c0808, 24'h1c0000, 24'h1cff1e, 24'h1d9c00};
	logic [7:0]  regs [7] = '{8'h14, 8'h15, 8'h1c, 8'h1d, 8'h1f, 8'h20, 8'h21};
	pscr_regs u_dut (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
		.external_clock(external_clock), .battery_compare_result(battery_compare_result),
		.doubler_enable(ctl[8]), .doubler_clock_enable(doubler_clock_enable),
		.supply_output_switch_enable(ctl[7]), .battery_compare_input_select(ctl[6:5]),
		.battery_comparator_enable(ctl[4]), .reference_and_temp_sensor_enable(ctl[3]),
		.regulator_enable(ctl[2]), .analog_ground_enable(ctl[1]), .analog_bias_enable(ctl[0]),
		.irq(irq));
	// ----------------------------------------------------------------
	// clock and external pin
	// ----------------------------------------------------------------
	always #10 ref_clk = ~ref_clk;
	// external clock of six system cycles, slow enough for the pin synchroniser
	always @(posedge ref_clk) begin
		ext_div <= (ext_div == 3'h5) ? 3'h0 : ext_div + 3'h1;
		external_clock <= (ext_div >= 3'h3);
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		if (n_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one avalon access; request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] adr, input logic [7:0] wd,
		input logic [3:0] be);
		int n;
		@(posedge ref_clk);
		avs_address <= adr;
		avs_writedata <= {24'h0, wd};
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0) begin
			n_errors++;
			$display("Error at %0t: bus access timed out", $time);
			stop_test();
		end
		rdata = avs_readdata;
		rresp = avs_response;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	// spacing of doubler clock pulses; the first gap may straddle a setting change
	task automatic gap(input int exp);
		int n;
		repeat (3) begin
			n = 0;
			do begin
				@(posedge ref_clk);
				n++;
			end while (doubler_clock_enable !== 1'b1 && n < 1000);
		end
		chk(n, exp);
	endtask : gap
	function automatic logic [31:0] exp_ctl();
		return {23'h0, exp_clk_ctrl[6], exp_supply[4:1], exp_analog[6:5], exp_analog[1:0]};
	endfunction : exp_ctl
	// every control output and register back at its reset value
	task automatic chk_reset();
		chk(ctl, 9'h0);
		chk(irq, 1'b0);
		chk(doubler_clock_enable, 1'b0);
		foreach (regs[i]) begin
			bus(1'b0, regs[i], 8'h00, 4'hf);
			chk(rdata, 32'h0);
			chk(rresp, 2'h0);
		end
	endtask : chk_reset
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		chk_reset();
		// table of writes: every output bit and every selector code, then read back
		foreach (rows[i]) begin
			bus(1'b1, rows[i][23:16], rows[i][15:8], 4'hf);
			if (rows[i][23:16] == REG_DOUBLER_CLOCK_CTRL) exp_clk_ctrl = rows[i][7:0];
			if (rows[i][23:16] == REG_SUPPLY_CTRL) exp_supply = rows[i][7:0];
			if (rows[i][23:16] == REG_ANALOG_ENABLES) exp_analog = rows[i][7:0];
			chk(ctl, exp_ctl());
			bus(1'b0, rows[i][23:16], 8'h00, 4'hf);
			chk(rdata, {24'h0, rows[i][7:0]});
		end
		// refused accesses leave everything as it was
		bus(1'b1, REG_ANALOG_ENABLES, 8'hff, 4'he);
		chk(ctl, exp_ctl());
		bus(1'b0, 8'h30, 8'h00, 4'hf);
		chk(rresp, 2'h2);
		// comparator result, read-only status and the interrupt
		bus(1'b1, REG_IRQ_MASK, 8'h01, 4'hf);
		battery_compare_result <= 1'b1;
		k = 0;
		while (irq !== 1'b1 && k < 20) begin
			@(posedge ref_clk);
			k++;
		end
		chk(irq, 1'b1);
		bus(1'b1, REG_BATTERY_STATUS, 8'h00, 4'hf);
		bus(1'b0, REG_BATTERY_STATUS, 8'h00, 4'hf);
		chk(rdata[31:1], 31'h0);
		chk(rdata[0], 1'b1);
		bus(1'b1, REG_IRQ_STATUS, 8'h01, 4'hf);
		chk(irq, 1'b0);
		battery_compare_result <= 1'b0;
		repeat (10) @(posedge ref_clk);
		chk(irq, 1'b0);
		bus(1'b0, REG_IRQ_STATUS, 8'h00, 4'hf);
		chk(rdata, 32'h2);
		// doubler clock rates; external source must override the select bit
		bus(1'b1, REG_DOUBLER_CLOCK_CTRL, 8'h41, 4'hf);
		gap(DIV_FAST);
		bus(1'b1, REG_DOUBLER_CLOCK_CTRL, 8'h40, 4'hf);
		gap(DIV_SLOW);
		bus(1'b1, REG_CLOCK_GATING, 8'h01, 4'hf);
		bus(1'b1, REG_DOUBLER_CLOCK_CTRL, 8'h41, 4'hf);
		gap(DIV_EXTERNAL * 6);
		// a reset in mid-run clears every register and stops the running doubler clock
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		chk_reset();
		stop_test();
	end
endmodule : test_pscr_regs
`default_nettype wire
